// file: src/pdz_pkg.sv
package pdz_pkg;

    // Command encodings seen on the three command pins (cmd[2:0] of the link).
    typedef enum logic [2:0] {
        PDZ_CMD_NOP = 3'h0,
        PDZ_CMD_ACT = 3'h1,
        PDZ_CMD_PRE = 3'h2,
        PDZ_CMD_REF = 3'h3,
        PDZ_CMD_RD = 3'h4,
        PDZ_CMD_MRS = 3'h5,
        PDZ_CMD_ZQL = 3'h6,
        PDZ_CMD_ZQS = 3'h7
    } pdz_cmd_t;

    // Device power states.
    typedef enum logic [2:0] {
        PDZ_ST_RESET = 3'h0,
        PDZ_ST_IDLE = 3'h1,
        PDZ_ST_ENTRY = 3'h2,
        PDZ_ST_PPD = 3'h3,
        PDZ_ST_APD = 3'h4,
        PDZ_ST_EXIT = 3'h5,
        PDZ_ST_CAL = 3'h6
    } pdz_state_t;

    // Controller sequencer states.
    typedef enum logic [2:0] {
        PDZ_HS_IDLE = 3'h0,
        PDZ_HS_ISSUE = 3'h1,
        PDZ_HS_PD = 3'h2,
        PDZ_HS_EXIT = 3'h3,
        PDZ_HS_WAIT = 3'h4
    } pdz_hstate_t;

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic DLL_SLOW_EXIT = 1'b0;
    localparam logic DLL_FAST_EXIT = 1'b1;
    localparam int REFI_LIMIT_MULT = 9;
    localparam int LINK_DIV = 8;
    localparam logic [3:0] LINK_DIV_LAST = 4'h7;

    // Saturating down-counter step.
    function automatic logic [CNT_W-1:0] dec_sat(input logic [CNT_W-1:0] v);
        return (v == CNT_ZERO) ? CNT_ZERO : v - CNT_ONE;
    endfunction

endpackage

// file: src/pdz_link_if.sv
`timescale 1ns/100ps
interface pdz_link_if;
    logic link_clk;
    logic cke;
    logic reset_n;
    logic term_ctrl;
    logic [2:0] cmd;
    logic [2:0] bank;
    modport dev (
        input link_clk,
        input cke,
        input reset_n,
        input term_ctrl,
        input cmd,
        input bank
    );
    modport host (
        output link_clk,
        output cke,
        output reset_n,
        output term_ctrl,
        output cmd,
        output bank
    );
endinterface

// file: src/pdz_device.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Enter power-down on clock-enable low with no-operation.
// - Controller keeps clock-enable high during busy commands.
// - All banks closed gives precharge, else active.
// - Controller resets loop after unlocked power-down exit; the host does not, it only waits the loop-dependent exit latency.
// - Buffers off; no-operation held through entry delay.
// - Active power-down keeps loop, always fast exit.
// - Mode bit 0 slow exit, 1 fast exit.
// - Slow exit: reads wait loop-dependent latency.
// - Controller holds clock-enable low, reset high.
// - Reset low forces exit into reset state.
// - Clock-enable low held minimum pulse before exit.
// - Clock-enable high held minimum pulse before entry.
// - Power-down no longer than nine refresh intervals.
// - Exit on clock-enable high with no-operation.
// - Refresh between exit and entry needs latencies.
// - After early entry, only no-operation until refresh done.
// - Long calibration: initial window first, operating after.
// - Short calibration within short window, 64 cycles.
// - Controller keeps channel quiet during calibration.
// - Banks precharged, termination off before calibration; the host ties termination off but does not check for open banks.
// - No recalibration on self-refresh exit unless commanded.
// - Shared resistor: calibration windows never overlap.
module pdz_device (
    // System
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Link
    pdz_link_if.dev link,
    // Configuration
    input wire logic dll_control_mode_bit_i,
    input wire logic dll_locked_i,
    input wire logic [pdz_pkg::CNT_W-1:0] entry_command_hold_delay_i,
    input wire logic [pdz_pkg::CNT_W-1:0] short_exit_latency_i,
    input wire logic [pdz_pkg::CNT_W-1:0] loop_dependent_exit_latency_i,
    input wire logic [pdz_pkg::CNT_W-1:0] initial_calibration_window_i,
    input wire logic [pdz_pkg::CNT_W-1:0] operating_calibration_window_i,
    input wire logic [pdz_pkg::CNT_W-1:0] short_calibration_window_i,
    // Status
    output logic in_powerdown_o,
    output logic active_powerdown_o,
    output logic dll_running_o,
    output logic cmd_rx_enabled_o,
    output logic io_buffers_enabled_o,
    output logic calibrating_o,
    output logic cal_update_o,
    output logic any_ready_o,
    output logic dll_ready_o,
    output logic in_reset_o
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [1:0] clk_sync;
        logic [1:0] rst_sync;
        logic [1:0] cke_sync;
        logic [1:0] term_sync;
        logic [5:0] cmd_sync;
        logic [5:0] bank_sync;
        logic clk_prev;
        pdz_pkg::pdz_state_t state;
        logic [7:0] open_banks;
        logic cal_done_once;
        logic slow_exit;
        logic apd;
        logic dll_on;
        logic rx_on;
        logic cal_upd;
        logic [pdz_pkg::CNT_W-1:0] ent_cnt;
        logic [pdz_pkg::CNT_W-1:0] xp_cnt;
        logic [pdz_pkg::CNT_W-1:0] xpdll_cnt;
        logic [pdz_pkg::CNT_W-1:0] cal_cnt;
    } pdz_dev_t;

    pdz_dev_t q;
    pdz_dev_t d;
    logic edge_w;
    logic cke_w;
    pdz_pkg::pdz_cmd_t cmd_w;

    // No open bank decides both the kind of power-down and whether the loop may stop.
    function automatic logic banks_closed(input logic [7:0] open_mask);
        return (open_mask == 8'h00);
    endfunction

    assign edge_w = q.clk_sync[1] & ~q.clk_prev;
    assign cke_w = q.cke_sync[1];
    assign cmd_w = pdz_pkg::pdz_cmd_t'(q.cmd_sync[5:3]);

    always_comb begin
        d = q;
        d.cal_upd = 1'b0;
        // Link pins are asynchronous to clk_sys_i, so each passes two flops.
        d.clk_sync = {q.clk_sync[0], link.link_clk};
        d.rst_sync = {q.rst_sync[0], link.reset_n};
        d.cke_sync = {q.cke_sync[0], link.cke};
        d.term_sync = {q.term_sync[0], link.term_ctrl};
        d.cmd_sync = {q.cmd_sync[2:0], link.cmd};
        d.bank_sync = {q.bank_sync[2:0], link.bank};
        d.clk_prev = q.clk_sync[1];
        if (!q.rst_sync[1]) begin
            d.state = pdz_pkg::PDZ_ST_RESET;
            d.open_banks = 8'h00;
            d.cal_done_once = 1'b0;
            d.dll_on = 1'b1;
            d.rx_on = 1'b1;
            // Power-down status is cleared too, so a reset leaves either kind of power-down.
            d.apd = 1'b0;
            d.slow_exit = 1'b0;
            d.ent_cnt = pdz_pkg::CNT_ZERO;
            d.xp_cnt = pdz_pkg::CNT_ZERO;
            d.xpdll_cnt = pdz_pkg::CNT_ZERO;
            d.cal_cnt = pdz_pkg::CNT_ZERO;
        end else if (edge_w) begin
            d.ent_cnt = pdz_pkg::dec_sat(q.ent_cnt);
            d.xp_cnt = pdz_pkg::dec_sat(q.xp_cnt);
            d.xpdll_cnt = pdz_pkg::dec_sat(q.xpdll_cnt);
            d.cal_cnt = pdz_pkg::dec_sat(q.cal_cnt);
            unique case (q.state)
                pdz_pkg::PDZ_ST_RESET: begin
                    d.state = pdz_pkg::PDZ_ST_IDLE;
                end
                pdz_pkg::PDZ_ST_IDLE, pdz_pkg::PDZ_ST_EXIT: begin
                    if (q.state == pdz_pkg::PDZ_ST_EXIT && q.xp_cnt <= pdz_pkg::CNT_ONE) begin
                        d.state = pdz_pkg::PDZ_ST_IDLE;
                    end
                    if (!cke_w && cmd_w == pdz_pkg::PDZ_CMD_NOP) begin
                        d.state = pdz_pkg::PDZ_ST_ENTRY;
                        d.ent_cnt = entry_command_hold_delay_i;
                    end else if (cke_w && q.state == pdz_pkg::PDZ_ST_IDLE) begin
                        unique case (cmd_w)
                            pdz_pkg::PDZ_CMD_ACT: d.open_banks[q.bank_sync[5:3]] = 1'b1;
                            pdz_pkg::PDZ_CMD_PRE: d.open_banks[q.bank_sync[5:3]] = 1'b0;
                            pdz_pkg::PDZ_CMD_ZQL: begin
                                d.state = pdz_pkg::PDZ_ST_CAL;
                                d.cal_cnt = q.cal_done_once ? operating_calibration_window_i
                                                            : initial_calibration_window_i;
                                d.cal_done_once = 1'b1;
                            end
                            pdz_pkg::PDZ_CMD_ZQS: begin
                                d.state = pdz_pkg::PDZ_ST_CAL;
                                d.cal_cnt = short_calibration_window_i;
                            end
                            default: d.open_banks = q.open_banks;
                        endcase
                    end
                end
                pdz_pkg::PDZ_ST_ENTRY: begin
                    // Receivers stay on until the entry delay expires.
                    if (q.ent_cnt <= pdz_pkg::CNT_ONE) begin
                        d.rx_on = 1'b0;
                        d.apd = !banks_closed(q.open_banks);
                        d.state = banks_closed(q.open_banks) ? pdz_pkg::PDZ_ST_PPD : pdz_pkg::PDZ_ST_APD;
                        // An open bank keeps the loop running whatever the mode bit says.
                        d.slow_exit = banks_closed(q.open_banks) &&
                                      (dll_control_mode_bit_i == pdz_pkg::DLL_SLOW_EXIT);
                        d.dll_on = !(banks_closed(q.open_banks) &&
                                     (dll_control_mode_bit_i == pdz_pkg::DLL_SLOW_EXIT));
                    end
                end
                pdz_pkg::PDZ_ST_PPD, pdz_pkg::PDZ_ST_APD: begin
                    // Only clock-enable high with a no-operation command is watched here; other inputs are ignored.
                    if (cke_w && cmd_w == pdz_pkg::PDZ_CMD_NOP) begin
                        d.state = pdz_pkg::PDZ_ST_EXIT;
                        d.rx_on = 1'b1;
                        d.dll_on = 1'b1;
                        d.apd = 1'b0;
                        d.xp_cnt = short_exit_latency_i;
                        d.xpdll_cnt = q.slow_exit ? loop_dependent_exit_latency_i
                                                  : short_exit_latency_i;
                    end
                end
                pdz_pkg::PDZ_ST_CAL: begin
                    // New impedance values take effect with the update pulse at the end of the window.
                    if (q.cal_cnt <= pdz_pkg::CNT_ONE) begin
                        d.cal_upd = 1'b1;
                        d.state = pdz_pkg::PDZ_ST_IDLE;
                    end
                end
                default: d.state = pdz_pkg::PDZ_ST_RESET;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign in_powerdown_o = (q.state == pdz_pkg::PDZ_ST_PPD) || (q.state == pdz_pkg::PDZ_ST_APD);
    assign active_powerdown_o = q.apd;
    assign dll_running_o = q.dll_on & dll_locked_i;
    assign cmd_rx_enabled_o = q.rx_on;
    assign io_buffers_enabled_o = q.rx_on;
    assign calibrating_o = (q.state == pdz_pkg::PDZ_ST_CAL);
    assign cal_update_o = q.cal_upd;
    assign any_ready_o = (q.state == pdz_pkg::PDZ_ST_IDLE);
    assign dll_ready_o = (q.state == pdz_pkg::PDZ_ST_IDLE) && (q.xpdll_cnt == pdz_pkg::CNT_ZERO);
    assign in_reset_o = (q.state == pdz_pkg::PDZ_ST_RESET);

endmodule // pdz_device

// file: src/pdz_host.sv
`timescale 1ns/100ps
module pdz_host (
    // System
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Link
    pdz_link_if.host link,
    // User requests
    input wire logic req_valid_i,
    input wire logic [2:0] req_cmd_i,
    input wire logic [2:0] req_bank_i,
    input wire logic pd_req_i,
    input wire logic dev_reset_i,
    output logic req_ready_o,
    output logic in_pd_o,
    // Configuration
    input wire logic [pdz_pkg::CNT_W-1:0] min_clock_enable_pulse_i,
    input wire logic [pdz_pkg::CNT_W-1:0] short_exit_latency_i,
    input wire logic [pdz_pkg::CNT_W-1:0] loop_dependent_exit_latency_i,
    input wire logic [pdz_pkg::CNT_W-1:0] entry_command_hold_delay_i,
    input wire logic [pdz_pkg::CNT_W-1:0] refresh_cycle_time_i,
    input wire logic [pdz_pkg::CNT_W-1:0] max_powerdown_time_i,
    input wire logic [pdz_pkg::CNT_W-1:0] cal_window_i
);

    ////////////////////////////////////////////////////////////////////////////

    typedef struct packed {
        logic [3:0] div;
        logic lclk;
        pdz_pkg::pdz_hstate_t st;
        logic cke;
        logic rst_n;
        logic [2:0] cmd;
        logic [2:0] bank;
        logic [pdz_pkg::CNT_W-1:0] cke_cnt;
        logic [pdz_pkg::CNT_W-1:0] xp_cnt;
        logic [pdz_pkg::CNT_W-1:0] xpdll_cnt;
        logic [pdz_pkg::CNT_W-1:0] rfc_cnt;
        logic [pdz_pkg::CNT_W-1:0] pd_cnt;
        logic [pdz_pkg::CNT_W-1:0] busy_cnt;
    } pdz_host_t;

    pdz_host_t q;
    pdz_host_t d;
    logic tick_w;
    logic may_enter_w;
    logic may_issue_w;

    // The link clock is a divided copy of clk_sys_i; cmd and bank change on a tick one cycle before its rising edge, cke also on reset, reset_n on any cycle.
    assign tick_w = (q.div == pdz_pkg::LINK_DIV_LAST);
    assign may_enter_w = (q.cke_cnt == pdz_pkg::CNT_ZERO) && (q.xpdll_cnt == pdz_pkg::CNT_ZERO) &&
                         (q.rfc_cnt == pdz_pkg::CNT_ZERO) && (q.busy_cnt == pdz_pkg::CNT_ZERO);
    // Reads need a running loop, so they also wait out the loop-dependent exit latency.
    assign may_issue_w = q.cke && (q.xp_cnt == pdz_pkg::CNT_ZERO) && (q.busy_cnt == pdz_pkg::CNT_ZERO) &&
                         (q.rfc_cnt == pdz_pkg::CNT_ZERO) &&
                         ((req_cmd_i != 3'(pdz_pkg::PDZ_CMD_RD)) || (q.xpdll_cnt == pdz_pkg::CNT_ZERO));

    always_comb begin
        d = q;
        d.div = tick_w ? 4'h0 : q.div + 4'h1;
        d.lclk = (q.div < 4'h4);
        d.rst_n = ~dev_reset_i;
        if (tick_w) begin
            d.cke_cnt = pdz_pkg::dec_sat(q.cke_cnt);
            d.xp_cnt = pdz_pkg::dec_sat(q.xp_cnt);
            d.xpdll_cnt = pdz_pkg::dec_sat(q.xpdll_cnt);
            d.rfc_cnt = pdz_pkg::dec_sat(q.rfc_cnt);
            d.pd_cnt = pdz_pkg::dec_sat(q.pd_cnt);
            d.busy_cnt = pdz_pkg::dec_sat(q.busy_cnt);
            d.cmd = 3'(pdz_pkg::PDZ_CMD_NOP);
            unique case (q.st)
                pdz_pkg::PDZ_HS_IDLE: begin
                    if (!q.cke) begin
                        // Clock-enable rises on a tick after reset, with a full pulse time before any entry.
                        d.cke = 1'b1;
                        d.cke_cnt = min_clock_enable_pulse_i;
                    end else if (pd_req_i && may_enter_w) begin
                        d.cke = 1'b0;
                        d.cke_cnt = min_clock_enable_pulse_i;
                        d.pd_cnt = max_powerdown_time_i;
                        d.st = pdz_pkg::PDZ_HS_PD;
                    end else if (req_valid_i && may_issue_w) begin
                        d.cmd = req_cmd_i;
                        d.bank = req_bank_i;
                        if (req_cmd_i == 3'(pdz_pkg::PDZ_CMD_ZQL) || req_cmd_i == 3'(pdz_pkg::PDZ_CMD_ZQS)) begin
                            d.busy_cnt = cal_window_i;
                        end
                        if (req_cmd_i == 3'(pdz_pkg::PDZ_CMD_REF)) begin
                            d.rfc_cnt = refresh_cycle_time_i;
                        end
                        if (req_cmd_i == 3'(pdz_pkg::PDZ_CMD_RD)) begin
                            d.busy_cnt = q.xpdll_cnt | entry_command_hold_delay_i;
                        end
                    end
                end
                pdz_pkg::PDZ_HS_PD: begin
                    // Leave early when the refresh limit is near, whatever the user wants.
                    if (q.cke_cnt == pdz_pkg::CNT_ZERO && (!pd_req_i || q.pd_cnt <= pdz_pkg::CNT_ONE)) begin
                        d.cke = 1'b1;
                        d.cke_cnt = min_clock_enable_pulse_i;
                        d.xp_cnt = short_exit_latency_i;
                        d.xpdll_cnt = loop_dependent_exit_latency_i;
                        d.st = pdz_pkg::PDZ_HS_IDLE;
                    end
                end
                default: d.st = pdz_pkg::PDZ_HS_IDLE;
            endcase
        end
        if (dev_reset_i) begin
            // Clock-enable stays low through reset so no short high pulse reaches the device.
            d.st = pdz_pkg::PDZ_HS_IDLE;
            d.cke = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    assign link.link_clk = q.lclk;
    assign link.cke = q.cke;
    assign link.reset_n = q.rst_n;
    assign link.term_ctrl = 1'b0;
    assign link.cmd = q.cmd;
    assign link.bank = q.bank;
    assign req_ready_o = tick_w && (q.st == pdz_pkg::PDZ_HS_IDLE) && !(pd_req_i && may_enter_w) && may_issue_w;
    assign in_pd_o = (q.st == pdz_pkg::PDZ_HS_PD);

endmodule // pdz_host

// file: sim/pdz_link_assertions.sv
`timescale 1ns/100ps
module pdz_link_assertions #(
    parameter int CKE_MIN_SYS = 24,
    parameter int PD_MAX_SYS = 160
) (
    // System
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // Link
    input wire logic link_clk,
    input wire logic cke,
    input wire logic reset_n,
    input wire logic term_ctrl,
    input wire logic [2:0] cmd,
    input wire logic [2:0] bank
);
    ////////////////////////////////////////////////////////////////////////////////
    // Length of the present clock-enable level; it saturates so long idle runs cannot wrap.
    logic [15:0] run_q;
    logic cke_q;
    logic woke_q;
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_q <= 16'h0000;
            cke_q <= 1'b0;
            woke_q <= 1'b0;
        end else begin
            cke_q <= cke;
            woke_q <= woke_q | cke;
            if (cke != cke_q) begin
                run_q <= 16'h0001;
            end else if (run_q != 16'hFFFF) begin
                run_q <= run_q + 16'h0001;
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking dc @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    chk_link_clk_runs: assert property ($rose(link_clk) |=> !$rose(link_clk) [*7] ##1 $rose(link_clk))
        else $error("link clock period broken");
    chk_pd_cmd_nop: assert property (!cke |-> cmd == pdz_pkg::PDZ_CMD_NOP)
        else $error("command during power-down");
    chk_exit_nop: assert property ($rose(cke) && woke_q |-> (cmd == pdz_pkg::PDZ_CMD_NOP) [*8])
        else $error("command too soon after exit");
    chk_low_pulse: assert property (cke && !cke_q && woke_q |-> run_q >= CKE_MIN_SYS)
        else $error("clock-enable low pulse too short");
    chk_high_pulse: assert property (!cke && cke_q |-> run_q >= CKE_MIN_SYS)
        else $error("clock-enable high pulse too short");
    chk_pd_limit: assert property (!cke && !cke_q && woke_q && reset_n |-> run_q <= PD_MAX_SYS)
        else $error("power-down held too long");
    chk_term_off: assert property (!term_ctrl)
        else $error("termination control raised");
    chk_cal_quiet: assert property ($changed(cmd) &&
        (cmd == pdz_pkg::PDZ_CMD_ZQL || cmd == pdz_pkg::PDZ_CMD_ZQS) |-> ##8 (cmd == pdz_pkg::PDZ_CMD_NOP) [*8])
        else $error("channel busy during calibration");
    chk_refresh_quiet: assert property ($changed(cmd) && cmd == pdz_pkg::PDZ_CMD_REF
        |-> ##8 (cmd == pdz_pkg::PDZ_CMD_NOP) [*8])
        else $error("command inside refresh time");
endmodule // pdz_link_assertions

// file: sim/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    localparam int L = pdz_pkg::LINK_DIV;
    localparam int ENT = 2;
    localparam int XP = 2;
    localparam int XPD = 6;
    localparam int CKE = 3;
    localparam int MPD = 20;
    localparam int ZI = 6;
    localparam int ZO = 4;
    localparam int ZS = 3;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic req_valid = 1'b0;
    logic [2:0] req_cmd = 3'h0;
    logic [2:0] req_bank = 3'h0;
    logic pd_req = 1'b0;
    logic dev_reset = 1'b0;
    logic dll_mode = 1'b0;
    logic req_ready, in_pd, pd_on, apd, dll_run, rx_en, io_en, cal, cal_upd, any_rdy, dll_rdy, in_rst;
    logic [7:0] open_q = 8'h00;
    int err_count = 0;
    int comparisons = 0;
    integer seed = 32'hED44;
    always #5 clk_sys_i = ~clk_sys_i;
    ////////////////////////////////////////////////////////////////////////////////
    pdz_link_if pdz_link_if_i ();
    pdz_host pdz_host_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .link(pdz_link_if_i.host),
        .req_valid_i(req_valid), .req_cmd_i(req_cmd), .req_bank_i(req_bank), .pd_req_i(pd_req),
        .dev_reset_i(dev_reset), .req_ready_o(req_ready), .in_pd_o(in_pd), .min_clock_enable_pulse_i(16'(CKE)),
        .short_exit_latency_i(16'(XP)), .loop_dependent_exit_latency_i(16'(XPD)),
        .entry_command_hold_delay_i(16'(ENT)), .refresh_cycle_time_i(16'h0004),
        .max_powerdown_time_i(16'(MPD)), .cal_window_i(16'h0008));
    pdz_device pdz_device_i (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .link(pdz_link_if_i.dev),
        .dll_control_mode_bit_i(dll_mode), .dll_locked_i(1'b1), .entry_command_hold_delay_i(16'(ENT)),
        .short_exit_latency_i(16'(XP)), .loop_dependent_exit_latency_i(16'(XPD)),
        .initial_calibration_window_i(16'(ZI)), .operating_calibration_window_i(16'(ZO)),
        .short_calibration_window_i(16'(ZS)), .in_powerdown_o(pd_on), .active_powerdown_o(apd),
        .dll_running_o(dll_run), .cmd_rx_enabled_o(rx_en), .io_buffers_enabled_o(io_en), .calibrating_o(cal),
        .cal_update_o(cal_upd), .any_ready_o(any_rdy), .dll_ready_o(dll_rdy), .in_reset_o(in_rst));
    pdz_link_assertions #(.CKE_MIN_SYS(CKE * L), .PD_MAX_SYS(MPD * L)) pdz_link_assertions_i (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .link_clk(pdz_link_if_i.link_clk), .cke(pdz_link_if_i.cke),
        .reset_n(pdz_link_if_i.reset_n), .term_ctrl(pdz_link_if_i.term_ctrl), .cmd(pdz_link_if_i.cmd),
        .bank(pdz_link_if_i.bank));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("Counts: %0d mismatches, %0d comparisons", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        comparisons++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask
    task automatic stuck(input int k);
        err_count++;
        $display("[ERR] wait %0d expected level seen timeout", k);
        test_done();
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return pdz_link_if_i.cke;
            1: return pd_on;
            2: return any_rdy;
            3: return dll_rdy;
            4: return cal;
            default: return in_rst;
        endcase
    endfunction
    // Waits are counted in system cycles so latencies can be measured by the same loop.
    task automatic wait_for(input int k, input logic lvl, input int lim, output int n);
        n = 0;
        while (pick(k) !== lvl) begin
            @(posedge clk_sys_i);
            n++;
            if (n >= lim) stuck(k);
        end
    endtask
    task automatic send(input logic [2:0] c, input logic [2:0] b);
        int n;
        @(posedge clk_sys_i);
        req_valid <= 1'b1;
        req_cmd <= c;
        req_bank <= b;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
            if (n >= 2000) stuck(9);
        end while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        if (c == pdz_pkg::PDZ_CMD_ACT) open_q[b] = 1'b1;
        if (c == pdz_pkg::PDZ_CMD_PRE) open_q[b] = 1'b0;
    endtask
    task automatic close_all();
        for (int b = 0; b < 8; b++) begin
            if (open_q[b]) send(pdz_pkg::PDZ_CMD_PRE, 3'(b));
        end
    endtask
    task automatic cal_run(input logic [2:0] c, input int win);
        int n;
        int u;
        send(c, 3'h0);
        wait_for(4, 1'b1, 100, n);
        u = 0;
        n = 0;
        while (cal === 1'b1) begin
            @(posedge clk_sys_i);
            n++;
            u += int'(cal_upd === 1'b1);
            if (n >= 1000) stuck(4);
        end
        repeat (4) begin
            @(posedge clk_sys_i);
            u += int'(cal_upd === 1'b1);
        end
        chk_rng("cal window", win * L - L, win * L + L, n);
        chk("cal update", 16'h0001, 16'(u));
    endtask
    task automatic pd_cycle(input logic mode);
        int n;
        int m;
        logic keep;
        keep = (|open_q) | mode;
        @(posedge clk_sys_i);
        dll_mode <= mode;
        pd_req <= 1'b1;
        wait_for(1, 1'b1, 600, n);
        repeat (ENT * L + 16) @(posedge clk_sys_i);
        chk("active pd", 16'(|open_q), 16'(apd));
        chk("dll running", 16'(keep), 16'(dll_run));
        chk("cmd rx", 16'h0000, 16'(rx_en));
        chk("io buffers", 16'h0000, 16'(io_en));
        chk("host in pd", 16'h0001, 16'(in_pd));
        pd_req <= 1'b0;
        wait_for(0, 1'b1, 600, n);
        wait_for(2, 1'b1, 600, n);
        chk_rng("short exit", XP * L - L, XP * L + 2 * L, n);
        chk("loop ready", 16'(keep), 16'(dll_rdy));
        if (!keep) begin
            wait_for(3, 1'b1, 600, m);
            chk_rng("loop exit", XPD * L - L, XPD * L + 2 * L, n + m);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        logic [31:0] r;
        repeat (20) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        repeat (12) @(posedge clk_sys_i);
        cal_run(pdz_pkg::PDZ_CMD_ZQL, ZI);
        cal_run(pdz_pkg::PDZ_CMD_ZQL, ZO);
        cal_run(pdz_pkg::PDZ_CMD_ZQS, ZS);
        pd_cycle(1'b0);
        pd_cycle(1'b1);
        send(pdz_pkg::PDZ_CMD_ACT, 3'h5);
        pd_cycle(1'b0);
        for (int i = 0; i < 8; i++) begin
            repeat (3) begin
                r = $random(seed);
                send(r[0] ? pdz_pkg::PDZ_CMD_ACT : pdz_pkg::PDZ_CMD_PRE, r[3:1]);
            end
            if (r[4]) begin
                close_all();
                send(pdz_pkg::PDZ_CMD_REF, 3'h0);
            end
            pd_cycle(r[5]);
        end
        // The host must leave power-down on its own even while power-down is still requested.
        close_all();
        @(posedge clk_sys_i);
        pd_req <= 1'b1;
        wait_for(0, 1'b0, 600, n);
        wait_for(0, 1'b1, (MPD + 6) * L, n);
        chk_rng("pd limit", MPD * L - L, MPD * L, n);
        pd_req <= 1'b0;
        wait_for(2, 1'b1, 1200, n);
        @(posedge clk_sys_i);
        pd_req <= 1'b1;
        wait_for(1, 1'b1, 600, n);
        dev_reset <= 1'b1;
        wait_for(5, 1'b1, 100, n);
        chk("pd after reset", 16'h0000, 16'(pd_on));
        chk("rx after reset", 16'h0001, 16'(rx_en));
        repeat (4 * L) @(posedge clk_sys_i);
        pd_req <= 1'b0;
        dev_reset <= 1'b0;
        open_q = 8'h00;
        wait_for(5, 1'b0, 200, n);
        repeat (4 * L) @(posedge clk_sys_i);
        cal_run(pdz_pkg::PDZ_CMD_ZQL, ZI);
        test_done();
    end
endmodule // tb_top
